// ==== scn_seq.sv ====
`timescale 1ns/1ps
// Overview of operation
// - list length is last minus first plus one
// - stepping pulses trigger after every channel closure
// - scanning pulses trigger once per completed scan
// - halt stops run, returns to idle
// - step interval is larger of timer, delay
// - first scan at start, next after timer
// - within scan only delay spaces channels
// - timer off: delay alone spaces channels
// - reading count accepted up to 1024
// - stepping wraps list until count reached
// - whole scans cover count, store only count
// - auto delay settles relays, manual capped
// - timer period in milliseconds up to limit
// - source selectable internal card or external
// - increment, decrement move the closed channel
// - open present channel before closing another
// - continuous mode rereads held channel per period
// - selectable channels are one through ten
// - scan run ends after final last channel
module scn_seq #(
  parameter int unsigned CYC_PER_MS = scn_pkg::MS_CYC,
  parameter int unsigned DEPTH      = 1024,
  parameter int unsigned DW         = 24
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic [DW-1:0]           meas_data,
  output logic      [scn_pkg::NCH-1:0] relay_close,
  output logic      [3:0]              ext_chan,
  output logic                         ext_step,
  output logic                         trig_out,
  output logic                         meas_strobe
);
  import scn_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  scn_tmr_if dly_if ();
  scn_tmr_if gap_if ();
  scn_rly_if rly_if ();

  // bus side
  logic          ph_q;
  logic [7:0]    wa_q;
  logic          sel;
  logic          wr_en;
  logic [31:0]   rdata;
  // configuration
  logic          tmr_en_q;
  logic          ext_q;
  logic          man_q;
  logic          cont_q;
  logic [3:0]    first_q;
  logic [3:0]    last_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic [31:0]   tper_q;
  logic [31:0]   dly_q;
  logic [AW-1:0] bidx_q;
  // sequencer
  scn_state_e    state_q;
  logic          run_q;
  logic          scan_q;
  logic [3:0]    chan_q;
  logic [CW-1:0] stored_q;
  logic [CW-1:0] stored_inc;
  logic          go_close_q;
  logic          dly_load_q;
  logic          gap_load_q;
  logic          cont_arm_q;
  logic [DW-1:0] last_rdg_q;
  logic [DW-1:0] buf_q [DEPTH];
  // relay commands
  logic          rly_req_q;
  logic [3:0]    rly_chan_q;
  logic          rly_open_q;
  logic [3:0]    cur_ch_q;
  logic          man_go;
  logic [3:0]    man_ch;
  // decoded strobes
  logic          start_step;
  logic          start_scan;
  logic          halt;
  logic          chan_cmd;
  logic          list_ok;
  logic          at_last;
  logic          cont_ok;

  // limit a time entry to 99h 99m 99.999s
  function automatic logic [31:0] hms_clamp(input logic [31:0] v);
    return (v > MAX_HMS_MS) ? MAX_HMS_MS : v;
  endfunction

  // any single word access is taken, hsize is not checked
  assign sel        = hsel && hready && htrans[1];
  assign wr_en      = ph_q;
  assign start_step = wr_en && wa_q == OFF_CTRL && hwdata[C_STEP];
  assign start_scan = wr_en && wa_q == OFF_CTRL && hwdata[C_SCAN];
  assign halt       = wr_en && wa_q == OFF_CTRL && hwdata[C_HALT];
  assign chan_cmd   = wr_en && wa_q == OFF_CHAN && !run_q && !halt;
  assign list_ok    = first_q >= CH_FIRST && last_q <= CH_LAST && last_q >= first_q;
  assign at_last    = chan_q == last_q;
  assign stored_inc = stored_q + CW'(1);
  assign cont_ok    = cont_q && tmr_en_q && cur_ch_q != 4'h0 && !ext_q;

  // timer hookup, auto delay just covers relay settling
  assign dly_if.load      = dly_load_q;
  assign dly_if.period_ms = man_q ? dly_q : AUTO_DLY_MS;
  assign gap_if.load      = gap_load_q;
  assign gap_if.period_ms = tper_q;
  assign rly_if.req       = rly_req_q;
  assign rly_if.chan      = rly_chan_q;
  assign rly_if.open_all  = rly_open_q;
  assign relay_close      = rly_if.closed;

  scn_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_dly_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .t       (dly_if.tmr)
  );

  scn_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_gap_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .t       (gap_if.tmr)
  );

  scn_relay_drv #(.BREAK_CYC(BREAK_CYC)) u_relay (
    .hclk    (hclk),
    .hresetn (hresetn),
    .r       (rly_if.drv)
  );

  // ahb-lite slave, zero wait states, read data registered in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q      <= 1'b0;
      wa_q      <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ph_q      <= sel && hwrite;
      if (sel) begin
        wa_q <= haddr[7:0];
      end
      hrdata <= (sel && !hwrite) ? rdata : 32'h0000_0000;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFF_CTRL: begin
        rdata[C_TMR]  = tmr_en_q;
        rdata[C_EXT]  = ext_q;
        rdata[C_MAN]  = man_q;
        rdata[C_CONT] = cont_q;
      end
      OFF_LIST: begin
        rdata[L_FIRST_LSB +: 4] = first_q;
        rdata[L_LAST_LSB +: 4]  = last_q;
      end
      OFF_COUNT: rdata[CW-1:0] = count_q;
      OFF_TIMER: rdata = tper_q;
      OFF_DELAY: rdata = dly_q;
      OFF_STATUS: begin
        rdata[S_RUN]            = run_q;
        rdata[S_SCAN]           = scan_q;
        rdata[S_CH_LSB +: 4]    = cur_ch_q;
        rdata[S_LEN_LSB +: 5]   = list_ok ? scn_list_len(first_q, last_q) : 5'h00;
        rdata[S_CNT_LSB +: CW]  = stored_q;
      end
      OFF_CHAN:  rdata[3:0]    = cur_ch_q;
      OFF_BIDX:  rdata[AW-1:0] = bidx_q;
      OFF_BDATA: rdata[DW-1:0] = buf_q[bidx_q];
      OFF_LAST:  rdata[DW-1:0] = last_rdg_q;
      default:   rdata = 32'h0000_0000;
    endcase
  end

  // reading count: zero becomes one, anything past depth is capped
  always_comb begin
    count_d = hwdata[CW-1:0];
    if (hwdata[31:CW] != '0 || hwdata[CW-1:0] > CW'(DEPTH)) begin
      count_d = CW'(DEPTH);
    end else if (hwdata[CW-1:0] == '0) begin
      count_d = CW'(1);
    end
  end

  // configuration; list and count frozen while a run uses them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_en_q <= 1'b0;
      ext_q    <= 1'b0;
      man_q    <= 1'b0;
      cont_q   <= 1'b0;
      first_q  <= CH_FIRST;
      last_q   <= CH_LAST;
      count_q  <= CW'(1);
      tper_q   <= RST_TIMER;
      dly_q    <= RST_DELAY;
      bidx_q   <= '0;
    end else if (wr_en) begin
      case (wa_q)
        OFF_CTRL: begin
          tmr_en_q <= hwdata[C_TMR];
          ext_q    <= hwdata[C_EXT];
          man_q    <= hwdata[C_MAN];
          cont_q   <= hwdata[C_CONT];
        end
        OFF_LIST: if (!run_q) begin
          first_q <= hwdata[L_FIRST_LSB +: 4];
          last_q  <= hwdata[L_LAST_LSB +: 4];
        end
        OFF_COUNT: if (!run_q) count_q <= count_d;
        OFF_TIMER: tper_q <= hms_clamp(hwdata);
        OFF_DELAY: dly_q  <= hms_clamp(hwdata);
        OFF_BIDX:  bidx_q <= hwdata[AW-1:0];
        default:   ;
      endcase
    end
  end

  // step/scan sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= ST_IDLE;
      run_q       <= 1'b0;
      scan_q      <= 1'b0;
      chan_q      <= CH_FIRST;
      stored_q    <= '0;
      go_close_q  <= 1'b0;
      dly_load_q  <= 1'b0;
      gap_load_q  <= 1'b0;
      cont_arm_q  <= 1'b0;
      trig_out    <= 1'b0;
      meas_strobe <= 1'b0;
      last_rdg_q  <= '0;
    end else begin
      go_close_q  <= 1'b0;
      dly_load_q  <= 1'b0;
      gap_load_q  <= 1'b0;
      trig_out    <= 1'b0;
      meas_strobe <= 1'b0;
      if (halt) begin
        state_q    <= ST_IDLE;
        run_q      <= 1'b0;
        scan_q     <= 1'b0;
        cont_arm_q <= 1'b0;
      end else begin
        unique case (state_q)
          // starts are only looked at here, so a run cannot be restarted
          ST_IDLE: begin
            if ((start_step || start_scan) && list_ok) begin
              run_q      <= 1'b1;
              scan_q     <= start_scan && !start_step;
              chan_q     <= first_q;
              stored_q   <= '0;
              go_close_q <= 1'b1;
              gap_load_q <= hwdata[C_TMR] && start_step; // this write's timer bit, not the old one
              cont_arm_q <= 1'b0;
              state_q    <= ST_CLOSE;
            end else if (cont_ok) begin
              if (!cont_arm_q) begin
                cont_arm_q <= 1'b1;
                gap_load_q <= 1'b1;
              end else if (gap_if.done) begin
                meas_strobe <= 1'b1;
                last_rdg_q  <= meas_data;
                gap_load_q  <= 1'b1;
              end
            end else begin
              cont_arm_q <= 1'b0;
            end
          end
          // wait out the relay request and any break time
          ST_CLOSE: begin
            if (!go_close_q && !rly_req_q && !rly_if.busy) begin
              dly_load_q <= 1'b1;
              state_q    <= ST_SETTLE;
            end
          end
          // per channel delay
          ST_SETTLE: begin
            if (gap_load_q) begin
              state_q <= ST_SETTLE;
            end else if (dly_if.done) begin
              state_q <= ST_STORE;
            end
          end
          ST_STORE: begin
            last_rdg_q <= meas_data;
            if (stored_q < count_q) begin
              stored_q    <= stored_inc;
              meas_strobe <= 1'b1;
            end
            if (!scan_q) begin
              trig_out <= 1'b1;
              if (stored_inc >= count_q) begin
                state_q <= ST_IDLE;
                run_q   <= 1'b0;
              end else begin
                chan_q <= at_last ? first_q : chan_q + 4'h1;
                if (tmr_en_q) begin
                  state_q <= ST_GAP;
                end else begin
                  go_close_q <= 1'b1;
                  state_q    <= ST_CLOSE;
                end
              end
            end else if (at_last) begin
              trig_out <= 1'b1;
              if (stored_inc >= count_q) begin
                state_q <= ST_IDLE;
                run_q   <= 1'b0;
                scan_q  <= 1'b0;
              end else begin
                chan_q <= first_q;
                if (tmr_en_q) begin
                  gap_load_q <= 1'b1;
                  state_q    <= ST_GAP;
                end else begin
                  go_close_q <= 1'b1;
                  state_q    <= ST_CLOSE;
                end
              end
            end else begin
              chan_q     <= chan_q + 4'h1;
              go_close_q <= 1'b1;
              state_q    <= ST_CLOSE;
            end
          end
          // step: rest of the timer period; scan: period after the scan
          ST_GAP: begin
            if (gap_if.done) begin
              go_close_q <= 1'b1;
              gap_load_q <= !scan_q;
              state_q    <= ST_CLOSE;
            end
          end
        endcase
      end
    end
  end

  // reading buffer, no reset needed on plain storage
  always_ff @(posedge hclk) begin
    if (state_q == ST_STORE && !halt && stored_q < count_q) begin
      buf_q[stored_q[AW-1:0]] <= meas_data;
    end
  end

  // manual channel command: inc, dec or direct close
  always_comb begin
    man_go = 1'b0;
    man_ch = cur_ch_q;
    if (hwdata[H_INC]) begin
      if (cur_ch_q < CH_LAST) begin
        man_go = 1'b1;
        man_ch = cur_ch_q + 4'h1;
      end
    end else if (hwdata[H_DEC]) begin
      if (cur_ch_q > CH_FIRST) begin
        man_go = 1'b1;
        man_ch = cur_ch_q - 4'h1;
      end
    end else if (hwdata[3:0] >= CH_FIRST && hwdata[3:0] <= CH_LAST) begin
      man_go = 1'b1;
      man_ch = hwdata[3:0];
    end
  end

  // relay and external channel requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rly_req_q  <= 1'b0;
      rly_chan_q <= CH_FIRST;
      rly_open_q <= 1'b0;
      cur_ch_q   <= 4'h0;
      ext_chan   <= 4'h0;
      ext_step   <= 1'b0;
    end else begin
      rly_req_q  <= 1'b0;
      rly_open_q <= 1'b0;
      ext_step   <= 1'b0;
      if (go_close_q) begin
        if (ext_q) begin
          ext_chan <= chan_q;
          ext_step <= 1'b1;
        end else begin
          rly_req_q  <= 1'b1;
          rly_chan_q <= chan_q;
          cur_ch_q   <= chan_q;
        end
      end else if (chan_cmd) begin
        if (hwdata[H_OPEN]) begin
          rly_open_q <= 1'b1;
          cur_ch_q   <= 4'h0;
        end else if (man_go) begin
          rly_req_q  <= 1'b1;
          rly_chan_q <= man_ch;
          cur_ch_q   <= man_ch;
        end
      end
    end
  end

  a_halt_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    halt |=> state_q == ST_IDLE && !run_q && !scan_q)
    else $error("halt did not return to idle");
  a_step_trig: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STORE && !scan_q && !halt |=> trig_out && !run_q || trig_out)
    else $error("step closure without trigger");
  a_scan_trig: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_out && $past(scan_q) |-> $past(chan_q) == $past(last_q))
    else $error("scan trigger before end of list");
  a_start_held: assert property (@(posedge hclk) disable iff (!hresetn)
    run_q && (start_step || start_scan) && !halt |=> stored_q >= $past(stored_q))
    else $error("start restarted an active run");
  a_count_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    (!run_q || stored_q <= count_q) && count_q <= CW'(DEPTH))
    else $error("stored readings exceed count");
  a_gap_timer: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_GAP |-> tmr_en_q || $past(tmr_en_q))
    else $error("timer gap with timer disabled");
  a_scan_inner: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STORE && scan_q && !at_last && !halt |=> state_q == ST_CLOSE ##1 rly_req_q || ext_step)
    else $error("scan channel spacing not by delay alone");
  a_step_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STORE && !scan_q && at_last && run_q && stored_inc < count_q && !halt
    |=> chan_q == first_q)
    else $error("stepping did not wrap to first channel");
endmodule

// ==== scn_pkg.sv ====
package scn_pkg;
  // clock and time base
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned MS_NS     = 1_000_000;
  localparam int unsigned MS_CYC    = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BREAK_NS  = 1_000;
  localparam int unsigned BREAK_CYC = (BREAK_NS + CLK_NS - 1) / CLK_NS;

  // channel range of the card
  localparam int unsigned NCH      = 10;
  localparam logic [3:0]  CH_FIRST = 4'h1;
  localparam logic [3:0]  CH_LAST  = 4'hA;

  // time limits in milliseconds, 99h 99m 99.999s
  localparam logic [31:0] AUTO_DLY_MS = 32'h0000_0001;
  localparam logic [31:0] MAX_HMS_MS  = 32'h159A_653F;

  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_LIST   = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_TIMER  = 8'h0C;
  localparam logic [7:0] OFF_DELAY  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_CHAN   = 8'h18;
  localparam logic [7:0] OFF_BIDX   = 8'h1C;
  localparam logic [7:0] OFF_BDATA  = 8'h20;
  localparam logic [7:0] OFF_LAST   = 8'h24;

  // field positions
  localparam int unsigned C_STEP = 0;
  localparam int unsigned C_SCAN = 1;
  localparam int unsigned C_HALT = 2;
  localparam int unsigned C_TMR  = 3;
  localparam int unsigned C_EXT  = 4;
  localparam int unsigned C_MAN  = 5;
  localparam int unsigned C_CONT = 6;
  localparam int unsigned L_FIRST_LSB = 0;
  localparam int unsigned L_LAST_LSB  = 8;
  localparam int unsigned H_OPEN = 4;
  localparam int unsigned H_INC  = 5;
  localparam int unsigned H_DEC  = 6;
  localparam int unsigned S_RUN  = 0;
  localparam int unsigned S_SCAN = 1;
  localparam int unsigned S_CH_LSB  = 4;
  localparam int unsigned S_LEN_LSB = 8;
  localparam int unsigned S_CNT_LSB = 16;

  // reset values
  localparam logic [31:0] RST_TIMER = 32'h0000_0000;
  localparam logic [31:0] RST_DELAY = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CLOSE  = 3'b001,
    ST_SETTLE = 3'b011,
    ST_STORE  = 3'b010,
    ST_GAP    = 3'b110
  } scn_state_e;

  // list length, caller guarantees last >= first
  function automatic logic [4:0] scn_list_len(input logic [3:0] first, input logic [3:0] last);
    return {1'b0, last} - {1'b0, first} + 5'h01;
  endfunction
endpackage

// ==== scn_if.sv ====
`timescale 1ns/1ps
// millisecond timer control
interface scn_tmr_if;
  logic        load;
  logic [31:0] period_ms;
  logic        done;
  modport ctl (output load, output period_ms, input done);
  modport tmr (input load, input period_ms, output done);
endinterface

// relay driver control
interface scn_rly_if;
  logic                    req;
  logic [3:0]              chan;
  logic                    open_all;
  logic                    busy;
  logic [scn_pkg::NCH-1:0] closed;
  modport ctl (output req, output chan, output open_all, input busy, input closed);
  modport drv (input req, input chan, input open_all, output busy, output closed);
endinterface

// ==== scn_ms_timer.sv ====
`timescale 1ns/1ps
module scn_ms_timer #(
  parameter int unsigned CYC_PER_MS = scn_pkg::MS_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  scn_tmr_if.tmr   t
);
  logic [31:0] cyc_q;
  logic [31:0] ms_q;
  logic        run_q;
  logic        done_q;

  // masked during load so a stale done is never seen
  assign t.done = done_q && !t.load;

  // ms prescaler and down counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_q  <= 32'h0000_0000;
      ms_q   <= 32'h0000_0000;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (t.load) begin
      ms_q   <= t.period_ms;
      cyc_q  <= 32'h0000_0000;
      run_q  <= 1'b1;
      done_q <= 1'b0;
    end else if (run_q) begin
      if (ms_q == 32'h0000_0000) begin
        run_q  <= 1'b0;
        done_q <= 1'b1;
      end else if (cyc_q == 32'(CYC_PER_MS - 1)) begin
        cyc_q <= 32'h0000_0000;
        ms_q  <= ms_q - 32'h0000_0001;
      end else begin
        cyc_q <= cyc_q + 32'h0000_0001;
      end
    end
  end

  a_tmr_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    t.load && t.period_ms == 32'h0000_0000 ##1 !t.load |=> t.done)
    else $error("zero period timer did not expire");
endmodule

// ==== scn_relay_drv.sv ====
`timescale 1ns/1ps
module scn_relay_drv #(
  parameter int unsigned BREAK_CYC = scn_pkg::BREAK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  scn_rly_if.drv   r
);
  import scn_pkg::*;

  logic [NCH-1:0] closed_q;
  logic           pend_q;
  logic [3:0]     pch_q;
  logic [15:0]    brk_q;

  function automatic logic [NCH-1:0] ch_bit(input logic [3:0] ch);
    return NCH'(1) << (ch - 4'h1);
  endfunction

  assign r.closed = closed_q;
  assign r.busy   = r.req || pend_q;

  // break before make: never two relays on the common bus at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      closed_q <= '0;
      pend_q   <= 1'b0;
      pch_q    <= 4'h0;
      brk_q    <= 16'h0000;
    end else if (r.open_all) begin
      closed_q <= '0;
      pend_q   <= 1'b0;
    end else if (r.req) begin
      if (closed_q != '0 && closed_q != ch_bit(r.chan)) begin
        closed_q <= '0;
        pend_q   <= 1'b1;
        pch_q    <= r.chan;
        brk_q    <= 16'(BREAK_CYC);
      end else begin
        closed_q <= ch_bit(r.chan);
      end
    end else if (pend_q) begin
      if (brk_q == 16'h0000) begin
        closed_q <= ch_bit(pch_q);
        pend_q   <= 1'b0;
      end else begin
        brk_q <= brk_q - 16'h0001;
      end
    end
  end

  a_open_first: assert property (@(posedge hclk) disable iff (!hresetn)
    closed_q != '0 && $past(closed_q) != '0 |-> closed_q == $past(closed_q))
    else $error("relay switched without opening first");
  a_one_closed: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot0(closed_q))
    else $error("more than one relay closed");
endmodule

// ==== scn_card_model.sv ====
`timescale 1ns/1ps
// relay card model: each channel returns a reading tagged with its number
module scn_card_model (
  input  wire logic [scn_pkg::NCH-1:0] relay_close,
  input  wire logic                    hclk,
  output logic      [23:0]             meas_data
);
  import scn_pkg::*;
  initial meas_data = 24'h000000;
  // open card floats: toggle every cycle, so a stale reading matches only on every other cycle
  always @(posedge hclk) begin
    meas_data <= ~meas_data;
    for (int i = 0; i < NCH; i++) begin
      if (relay_close[i] === 1'b1) begin
        meas_data <= {20'hC3A50, 4'(i + 1)};
      end
    end
  end
endmodule

// ==== scan_step_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module scan_step_sequencer_tb_top;
  import scn_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic        hreadyout, hresp, ext_step, trig_out, meas_strobe;
  logic [3:0]  ext_chan;
  logic [9:0]  relay_close;
  logic [23:0] meas_data;
  logic [9:0]  q_rc[$];
  logic [3:0]  q_ec[$];
  int          q_gap[$], cyc = 0, t_ext = 0;
  int          fail_count = 0, n_tests = 0, n_trig = 0, first, cnt, k;

  always #12.5 hclk = ~hclk;

  // short millisecond so delays stay a few cycles long
  scn_seq #(.CYC_PER_MS(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .meas_data(meas_data), .relay_close(relay_close), .ext_chan(ext_chan),
    .ext_step(ext_step), .trig_out(trig_out), .meas_strobe(meas_strobe));
  scn_card_model card_u (.relay_close(relay_close), .hclk(hclk), .meas_data(meas_data));

  // pulse monitor, pulses last a single cycle
  always @(posedge hclk) begin
    cyc++;
    if (ext_step === 1'b1) begin
      q_ec.push_back(ext_chan);
      q_gap.push_back(cyc - t_ext);
      t_ext = cyc;
    end
    if (trig_out === 1'b1) n_trig++;
    if (meas_strobe === 1'b1) q_rc.push_back(relay_close);
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    n_tests++;
    if (e !== a) begin
      $display("wrong value t=%0t exp=%h got=%h", $time, e, a);
      fail_count++;
    end
  endtask

  // bounded wait for hready, a stuck slave ends the run
  task automatic rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask

  // one single word transfer, read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask

  // poll status until the run stops
  task automatic wait_idle();
    for (k = 0; k < 300; k++) begin
      bus(1'b0, OFF_STATUS, 32'h0);
      if (r[S_RUN] === 1'b0) break;
    end
    if (k == 300) begin
      fail_count++;
      give_verdict();
    end
  endtask

  initial begin
    void'($urandom(32'h750B));
    first = 1 + $urandom % 5;
    cnt = 2 + $urandom % 6;
    repeat (2) @(posedge hclk);
    chk(32'h0, hrdata | {22'h0, relay_close});
    hresetn <= 1'b1;
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(32'hA, (r >> S_LEN_LSB) & 32'h1F);
    chk(32'h0, {hresp, ext_step, ext_chan});
    bus(1'b0, 8'h30, 32'h0);
    chk(32'h0, r);
    bus(1'b1, OFF_COUNT, 32'h7D0);
    bus(1'b0, OFF_COUNT, 32'h0);
    chk(32'h400, r);
    // step run over a three channel list that wraps
    bus(1'b1, OFF_LIST, (first + 2) << L_LAST_LSB | first);
    bus(1'b1, OFF_COUNT, cnt);
    q_rc.delete();
    n_trig = 0;
    bus(1'b1, OFF_CTRL, 1 << C_STEP);
    bus(1'b1, OFF_CTRL, 1 << C_SCAN);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(32'h0, r[S_SCAN]);
    wait_idle();
    chk(cnt, n_trig);
    chk(cnt, q_rc.size());
    chk(cnt, (r >> S_CNT_LSB) & 32'h7FF);
    for (int i = 0; i < cnt; i++) begin
      chk(1 << (first + i % 3 - 1), q_rc[i]);
      bus(1'b1, OFF_BIDX, i);
      bus(1'b0, OFF_BDATA, 32'h0);
      chk({20'hC3A50, 4'(first + i % 3)}, r);
    end
    // scan run, two scans of three channels for four readings
    bus(1'b1, OFF_LIST, 32'h0301);
    bus(1'b1, OFF_COUNT, 32'h4);
    n_trig = 0;
    bus(1'b1, OFF_CTRL, 1 << C_SCAN);
    wait_idle();
    chk(32'h2, n_trig);
    chk(32'h4, (r >> S_CNT_LSB) & 32'h7FF);
    // halt in mid run, no trigger may follow
    bus(1'b1, OFF_COUNT, 32'h400);
    bus(1'b1, OFF_CTRL, 1 << C_STEP);
    repeat (150) @(posedge hclk);
    bus(1'b1, OFF_CTRL, 1 << C_HALT);
    // off the edge, so a pulse counted at the halt edge is already in
    @(negedge hclk);
    k = n_trig;
    repeat (200) @(posedge hclk);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(32'h0, r[S_RUN]);
    chk(k, n_trig);
    // manual close, reclose with break, then increment
    bus(1'b1, OFF_CHAN, 32'h3);
    repeat (60) @(posedge hclk);
    chk(32'h004, relay_close);
    bus(1'b1, OFF_CHAN, 32'h5);
    repeat (10) @(posedge hclk);
    chk(32'h0, relay_close);
    repeat (60) @(posedge hclk);
    chk(32'h010, relay_close);
    bus(1'b1, OFF_CHAN, 1 << H_INC);
    repeat (60) @(posedge hclk);
    chk(32'h020, relay_close);
    // external step 9,10,9: timer 5 ms (50 cycles) outlasts 2 ms manual delay
    bus(1'b1, OFF_LIST, 32'h0A09);
    bus(1'b1, OFF_COUNT, 32'h3);
    bus(1'b1, OFF_TIMER, 32'h5);
    bus(1'b1, OFF_DELAY, 32'h2);
    q_ec.delete();
    q_gap.delete();
    bus(1'b1, OFF_CTRL, 1 << C_EXT | 1 << C_TMR | 1 << C_MAN | 1 << C_STEP);
    wait_idle();
    chk(32'h3, q_ec.size());
    for (int i = 0; i < 3; i++) begin
      chk(i == 1 ? 32'hA : 32'h9, q_ec[i]);
    end
    for (int i = 1; i < 3; i++) begin
      chk(32'h1, q_gap[i] >= 50 && q_gap[i] <= 60);
    end
    // decrement to channel 5, then continuous rereads once per timer period
    bus(1'b1, OFF_CHAN, 1 << H_DEC);
    q_rc.delete();
    bus(1'b1, OFF_CTRL, 1 << C_CONT | 1 << C_TMR);
    repeat (300) @(posedge hclk);
    chk(32'h1, q_rc.size() >= 5 && q_rc.size() <= 6);
    foreach (q_rc[i]) begin
      chk(32'h010, q_rc[i]);
    end
    give_verdict();
  end
endmodule
